// ===== dv/amc_asserts.sv
// concurrent checks on the amplifier control ports
`default_nettype none
module amc_asserts
   import amc_pkg::*;
#(
   parameter int HARD_CYC = 8 // hard mute ramp in cycles
) (
   input wire logic                   CLK_IN,            // core clock
   input wire logic                   RSTN_IN,           // async reset, active low
   input wire amc_pkg::amc_asel_t     ADDR_SEL_CODE_IN,  // address select code
   input wire logic                   SUPPLY_OK_IN,      // supply above 6 V
   input wire amc_pkg::amc_stb_t      STANDBY_LEVEL_IN,  // standby level
   input wire logic                   SCL_IN,            // bus clock level
   input wire logic [8*NUM_DATA-1:0]  FAULT_IN,          // live faults
   input wire logic [8*NUM_DATA-1:0]  FAULT_PIN_MASK_IN, // faults on the pin
   input wire logic                   SDA_OEN_OUT,       // data pull enable
   input wire logic                   FAULT_PIN_OEN_OUT, // fault pin enable
   input wire logic                   BUS_MODE_OUT,      // bus mode
   input wire logic [6:0]             SLAVE_ADDR_OUT,    // latched address
   input wire logic                   AMP_ON_OUT,        // powered
   input wire logic                   AMP_STARTED_OUT,   // started
   input wire logic [1:0]             PAIR_MUTED_OUT,    // pair mute state
   input wire logic                   HARD_MUTE_OUT,     // hard mute
   input wire logic [8*NUM_INSTR-1:0] INSTR_OUT,         // instruction bytes
   input wire logic [8*NUM_DATA-1:0]  FAULT_REPORT_PIN_LATCH_OUT,    // latched diagnostics
   input wire logic                   POR_FLAG_OUT       // reset flag
);
   localparam int H_MAX = HARD_CYC + 3;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   mode_sel_a: assert property (BUS_MODE_OUT == (ADDR_SEL_CODE_IN != ASEL_SHORT))
      else $error("mode does not follow address select");
   addr_hold_a: assert property (!SUPPLY_OK_IN && !$past(SUPPLY_OK_IN) |-> $stable(SLAVE_ADDR_OUT))
      else $error("address changed at low supply");
   bus_quiet_a: assert property (STANDBY_LEVEL_IN == STB_OFF && $past(STANDBY_LEVEL_IN) == STB_OFF
      |-> SDA_OEN_OUT)
      else $error("data line pulled in standby");
   hard_mute_a: assert property ($rose(HARD_MUTE_OUT) && AMP_STARTED_OUT
      |-> ##[0:H_MAX] PAIR_MUTED_OUT == 2'b11)
      else $error("hard mute too slow");
   soft_unmute_a: assert property ($fell(HARD_MUTE_OUT) && AMP_STARTED_OUT
      |=> $stable(PAIR_MUTED_OUT) [*8])
      else $error("abrupt unmute after hard mute");
   shut_order_a: assert property ($fell(AMP_ON_OUT) |-> $past(PAIR_MUTED_OUT) == 2'b11)
      else $error("shut down before muting");
   start_gate_a: assert property ($rose(AMP_STARTED_OUT) && BUS_MODE_OUT
      |-> INSTR_OUT[8*IB_FIRST+START_BIT])
      else $error("start without start bit");
   legacy_start_a: assert property (!BUS_MODE_OUT && STANDBY_LEVEL_IN != STB_OFF
      && $past(STANDBY_LEVEL_IN) == STB_OFF |-> ##[0:2] AMP_STARTED_OUT)
      else $error("legacy start late");
   por_pin_a: assert property ($rose(POR_FLAG_OUT) |=> !FAULT_PIN_OEN_OUT)
      else $error("fault pin not low after reset flag");
   fault_report_pin_keep_a: assert property (|($past(FAULT_REPORT_PIN_LATCH_OUT) & ~FAULT_REPORT_PIN_LATCH_OUT) |-> SCL_IN)
      else $error("latch cleared outside bus stop");
   pin_live_a: assert property ((FAULT_IN & FAULT_PIN_MASK_IN) == '0 && !POR_FLAG_OUT
      |=> FAULT_PIN_OEN_OUT)
      else $error("fault pin held without fault");
endmodule
bind amc_core amc_asserts #(.HARD_CYC(HARD_CYC)) chk_u (.CLK_IN, .RSTN_IN, .ADDR_SEL_CODE_IN, .SUPPLY_OK_IN,
   .STANDBY_LEVEL_IN, .SCL_IN, .FAULT_IN, .FAULT_PIN_MASK_IN, .SDA_OEN_OUT, .FAULT_PIN_OEN_OUT, .BUS_MODE_OUT,
   .SLAVE_ADDR_OUT, .AMP_ON_OUT, .AMP_STARTED_OUT, .PAIR_MUTED_OUT, .HARD_MUTE_OUT, .INSTR_OUT, .FAULT_REPORT_PIN_LATCH_OUT,
   .POR_FLAG_OUT);
`default_nettype wire

// ===== dv/amc_host.sv
// two-wire bus master model of the host controller
`default_nettype none
module amc_host (
   input  wire logic clk_in,  // core clock
   input  wire logic sda_in,  // resolved data line
   output var  logic scl_out, // bus clock, idle high between frames
   output var  logic sda_out  // high releases the data line
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // data moves one cycle after clock falls, sampled mid high phase
   task automatic bitx(input logic b, output logic r);
      scl_out = 1'b0;
      cyc(1);
      sda_out = b;
      cyc(3);
      scl_out = 1'b1;
      cyc(2);
      r = sda_in;
      cyc(2);
   endtask
   task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(a, ack);
   endtask
   // write bytes go out first to last
   task automatic frame(input logic [7:0] a, input int n, input logic [39:0] wd,
                        output logic [39:0] rd, output logic [5:0] acks);
      logic [7:0] q;
      rd = '0;
      acks = '0;
      sda_out = 1'b0;
      cyc(4);
      byte_x(a, 1'b1, q, acks[0]);
      for (int k = 0; k < n; k++) begin
         if (a[0]) byte_x(8'hff, k == n - 1, rd[8*k+:8], acks[k+1]);
         else byte_x(wd[8*k+:8], 1'b1, q, acks[k+1]);
      end
      scl_out = 1'b0;
      cyc(1);
      sda_out = 1'b0;
      cyc(3);
      scl_out = 1'b1;
      cyc(4);
      sda_out = 1'b1;
      cyc(4);
   endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// testbench: address select, standby sequencing, mute timing and diagnostic read-out
`default_nettype none
module tb;
   import amc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SOFT = 40;
   localparam int HARD = 8;
   logic clk = 1'b0, rstn = 1'b0, sup = 1'b0;
   amc_asel_t asel = ASEL_R100K;
   amc_stb_t stb = STB_OFF;
   logic [39:0] flt = '0, msk = '0, rd;
   logic [5:0] ack;
   wire logic scl, hsda, sda, oen, pin_oen, bmode, av, on, started, hm, cm, por, sdo, fpo;
   wire logic [6:0] sa;
   wire logic [1:0] pm;
   wire logic [31:0] ins;
   wire logic [39:0] dl;
   int miscompares = 0, num_checks = 0, cycles = 0;
   amc_asel_t codes[5] = '{ASEL_SHORT, ASEL_R10K, ASEL_R30K, ASEL_HIGH, ASEL_R100K};
   logic [7:0] abyte[5] = '{8'h00, 8'hd4, 8'hde, 8'hda, 8'hdc};
   logic [7:0] mv[4] = '{8'h04, 8'h02, 8'h01, 8'h00};
   logic [1:0] me[4] = '{2'b01, 2'b10, 2'b11, 2'b00};
   // data line has a pull-up; either party may pull it low
   assign sda = hsda & (oen | sdo);
   always #4 clk = ~clk;
   amc_host host_u (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(hsda));
   amc_core #(.SOFT_CYC(SOFT), .HARD_CYC(HARD)) dut_u (.CLK_IN(clk), .RSTN_IN(rstn), .ADDR_SEL_CODE_IN(asel),
      .SUPPLY_OK_IN(sup), .STANDBY_LEVEL_IN(stb), .SCL_IN(scl), .SDA_IN(sda), .FAULT_IN(flt),
      .FAULT_PIN_MASK_IN(msk), .SDA_OUT(sdo), .SDA_OEN_OUT(oen), .FAULT_PIN_OUT(fpo), .FAULT_PIN_OEN_OUT(pin_oen),
      .BUS_MODE_OUT(bmode), .ADDR_VALID_OUT(av), .SLAVE_ADDR_OUT(sa), .AMP_ON_OUT(on),
      .AMP_STARTED_OUT(started), .PAIR_MUTED_OUT(pm), .HARD_MUTE_OUT(hm), .CM_TRACK_SUPPLY_OUT(cm),
      .INSTR_OUT(ins), .FAULT_REPORT_PIN_LATCH_OUT(dl), .POR_FLAG_OUT(por));
   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         $display("ERROR %0t: run did not finish", $time);
         end_of_test();
      end
   end
   initial begin
      w(20);
      rstn = 1'b1;
      w(2);
      chk(48'({ins, por, on, pm, fpo}), 48'({32'h0, 5'b00110}));
      sup = 1'b1;
      foreach (codes[i]) begin
         asel = codes[i];
         w(3);
         chk(48'({bmode, av, sa & {7{i != 0}}}), 48'({{2{i != 0}}, abyte[i][7:1]}));
      end
      sup = 1'b0;
      asel = ASEL_R10K;
      w(3);
      chk(48'(sa), 48'(7'h6e));
      asel = ASEL_R100K;
      sup = 1'b1;
      w(3);
      host_u.frame(8'hdc, 4, 40'h0, rd, ack);
      chk(48'(ack[0]), 48'h1);
      stb = STB_OPER;
      w(4);
      chk(48'({on, started, por, pin_oen}), 48'(4'b1010));
      host_u.frame(8'hd4, 4, 40'h0, rd, ack);
      chk(48'(ack[0]), 48'h1);
      host_u.frame(8'hdc, 4, 40'h80000001, rd, ack);
      w(3);
      chk(48'({ack[4:0], ins, started, por, pin_oen, cm}), 48'({5'h0, 32'h80000001, 4'b1011}));
      w(SOFT + 10);
      chk(48'(pm), 48'h0);
      foreach (mv[i]) begin
         host_u.frame(8'hdc, 4, {8'h00, 8'h80, 8'h00, mv[i], 8'h01}, rd, ack);
         chk(48'({pm, hm}), 48'({me[i], i == 2}));
      end
      msk = 40'h1;
      flt = 40'h200001;
      w(3);
      chk(48'(pin_oen), 48'h0);
      flt = '0;
      w(3);
      chk(48'({dl, pin_oen}), 48'({40'h200001, 1'b1}));
      host_u.frame(8'hdd, 4, 40'h0, rd, ack);
      w(3);
      chk(48'({rd[31:0], dl[23:16], dl[7:0]}), 48'({32'h200001, 16'h2001}));
      host_u.frame(8'hdd, 5, 40'h0, rd, ack);
      chk(48'(rd), 48'h200001);
      host_u.frame(8'hdd, 5, 40'h0, rd, ack);
      chk(48'(rd | dl), 48'h0);
      stb = STB_OFF;
      w(1);
      chk(48'({hm, on}), 48'(2'b11));
      w(HARD + 10);
      chk(48'({on, pm}), 48'(3'b011));
      stb = STB_OPER;
      w(3);
      chk(48'({ins, por}), 48'({32'h0, 1'b1}));
      asel = ASEL_SHORT;
      stb = STB_MUTE;
      w(3);
      chk(48'({started, pm, ins}), 48'({3'b111, 32'h0}));
      stb = STB_OPER;
      w(SOFT / 2);
      chk(48'(pm), 48'(2'b11));
      w(SOFT);
      chk(48'(pm), 48'h0);
      stb = STB_MUTE;
      w(SOFT + 10);
      stb = STB_OFF;
      w(5);
      chk(48'({on, pm}), 48'(3'b011));
      stb = STB_OPER;
      w(2 * SOFT);
      stb = STB_OFF;
      w(1);
      chk(48'({hm, on, pm}), 48'(4'b1100));
      w(HARD + 10);
      chk(48'(on), 48'h0);
      end_of_test();
   end
endmodule
`default_nettype wire

// ===== src/amc_byte_if.sv
// byte level link between the two-wire slave and the control core
`default_nettype none
interface amc_byte_if;
   logic       en;
   logic [6:0] addr;
   logic [7:0] rd_data;
   logic       start;
   logic       stop;
   logic       rw;
   logic       wr_valid;
   logic [7:0] wr_data;
   logic       rd_done;
   modport slave (input en, addr, rd_data, output start, stop, rw, wr_valid, wr_data, rd_done);
   modport ctrl  (output en, addr, rd_data, input start, stop, rw, wr_valid, wr_data, rd_done);
endinterface
`default_nettype wire

// ===== src/amc_core.sv
// mode select, standby sequencing, mute timing and diagnostic latches
`default_nettype none
// Behaviour
// - a shorted address select pin selects legacy mode without bus traffic
// - pull-downs of 100k, 30k, 10k give addresses dc, de, d4
// - forced high voltage or pull-up on address select gives address da
// - address latched only while supply above 6 V; held below it
// - legacy standby is off, mute, operating; amplifier starts on mute or operating
// - legacy mute transitions are timed by a 15 ms timer
// - legacy operating to off applies hard mute within 400 us, then shuts down
// - bus mode with standby low: quiescent and no load on bus lines
// - bus mode standby high: operate, power-on reset, fault pin pulled low
// - start bit written one starts amplifier, clears reset flag, releases fault pin
// - front and rear pairs soft mute independently, each in 15 ms
// - hard mute mutes all four channels together within 400 us
// - release of hard mute unmutes softly over about 15 ms
// - bus mode standby low after start: hard mute first (soft mute if fourth byte bit 6 set), then shut down
// - diagnostic latch bits set on fault and stay set until read clears
// - latches clear only after a read of all five data bytes
// - enabled fault pin shows live fault, released as soon as fault clears
// - fourth instruction byte bit 7 makes common mode track the supply
// - a write transfer carries four instruction bytes, first through fourth
// - power-on reset clears every instruction bit to zero
module amc_core
   import amc_pkg::*;
#(
   parameter int SOFT_CYC = SOFT_MUTE_CYC, // soft mute ramp length in cycles
   parameter int HARD_CYC = HARD_MUTE_CYC  // hard mute ramp length in cycles
) (
   input  wire logic                     CLK_IN,              // core clock, 125 MHz
   input  wire logic                     RSTN_IN,             // async reset, active low
   input  wire amc_pkg::amc_asel_t       ADDR_SEL_CODE_IN,    // classified address select pin
   input  wire logic                     SUPPLY_OK_IN,        // supply above 6 V
   input  wire amc_pkg::amc_stb_t        STANDBY_LEVEL_IN,    // classified standby pin level
   input  wire logic                     SCL_IN,              // bus clock level
   input  wire logic                     SDA_IN,              // bus data level
   input  wire logic [8*NUM_DATA-1:0]    FAULT_IN,            // live fault sources per data bit
   input  wire logic [8*NUM_DATA-1:0]    FAULT_PIN_MASK_IN,   // faults reported on the fault pin
   output var  logic                     SDA_OUT,             // bus data drive value, always low
   output var  logic                     SDA_OEN_OUT,         // low while pulling bus data low
   output var  logic                     FAULT_PIN_OUT,       // fault pin drive value, always low
   output var  logic                     FAULT_PIN_OEN_OUT,   // low while pulling fault pin low
   output var  logic                     BUS_MODE_OUT,        // two-wire bus mode selected
   output var  logic                     ADDR_VALID_OUT,      // latched address is valid
   output var  logic [6:0]               SLAVE_ADDR_OUT,      // latched seven-bit address
   output var  logic                     AMP_ON_OUT,          // amplifier powered
   output var  logic                     AMP_STARTED_OUT,     // amplifier started and running
   output var  logic [1:0]               PAIR_MUTED_OUT,      // front (0) and rear (1) muted
   output var  logic                     HARD_MUTE_OUT,       // hard mute requested
   output var  logic                     CM_TRACK_SUPPLY_OUT, // ripple capacitor disconnected
   output var  logic [8*NUM_INSTR-1:0]   INSTR_OUT,           // instruction bytes, first in low byte
   output var  logic [8*NUM_DATA-1:0]    FAULT_REPORT_PIN_LATCH_OUT,      // latched diagnostic bits
   output var  logic                     POR_FLAG_OUT         // power-on reset occurred flag
);
   localparam int TW = $clog2(SOFT_CYC + 1);

   generate
      if (HARD_CYC < 1 || SOFT_CYC < HARD_CYC) begin : g_bad
         $error("amc_core: need 1 <= HARD_CYC <= SOFT_CYC");
      end
   endgenerate

   amc_byte_if bus ();

   amc_amp_t             amp_r;
   logic [7:0]           ib_r [NUM_INSTR];
   logic [2:0]           wr_idx_r;
   logic [2:0]           rd_cnt_r;
   logic                 rd_xfer_r;
   logic                 por_r;
   logic [6:0]           addr_r;
   logic                 addr_valid_r;
   logic [8*NUM_DATA-1:0] fault_report_pin_r;
   logic                 fault_oen_r;
   logic [1:0]           muted_r;
   logic [TW-1:0]        tmr_r [2];

   // mode and address decode
   // short selects legacy
   wire legacy     = (ADDR_SEL_CODE_IN == ASEL_SHORT);
   wire bus_mode   = ~legacy;
   wire stb_hi     = (STANDBY_LEVEL_IN != STB_OFF);
   wire stb_mute   = (STANDBY_LEVEL_IN == STB_MUTE);
   wire [7:0] asel_byte = (ADDR_SEL_CODE_IN == ASEL_R100K) ? ADDR_R100K :
                          (ADDR_SEL_CODE_IN == ASEL_R30K)  ? ADDR_R30K  :
                          (ADDR_SEL_CODE_IN == ASEL_R10K)  ? ADDR_R10K  : ADDR_HIGH;
   wire asel_ok    = (ADDR_SEL_CODE_IN == ASEL_R100K) || (ADDR_SEL_CODE_IN == ASEL_R30K) ||
                     (ADDR_SEL_CODE_IN == ASEL_R10K)  || (ADDR_SEL_CODE_IN == ASEL_HIGH);

   // bus events
   wire por_evt    = bus_mode & stb_hi & (amp_r == ST_OFF);
   wire ib_wr      = bus.wr_valid & bus_mode & (wr_idx_r < 3'(NUM_INSTR));
   wire start_wr   = ib_wr & (wr_idx_r == 3'(IB_FIRST)) & bus.wr_data[START_BIT];
   wire xfer_end   = bus.start | bus.stop;
   wire rd_clear   = xfer_end & rd_xfer_r & (rd_cnt_r == 3'(NUM_DATA));

   // mute requests
   wire in_shut    = (amp_r == ST_SHUT);
   wire amp_live   = (amp_r == ST_RUN) | in_shut;
   wire slow_shut  = bus_mode & ib_r[IB_FOURTH][SLOW_SHUT_BIT];
   wire hard_req   = (bus_mode & ib_r[IB_SECOND][FAST_MUTE_BIT]) | (in_shut & ~slow_shut);
   wire [1:0] soft_req;
   assign soft_req[0] = (bus_mode ? ib_r[IB_SECOND][FRONT_MUTE_BIT] : stb_mute) | (in_shut & slow_shut);
   assign soft_req[1] = (bus_mode ? ib_r[IB_SECOND][REAR_MUTE_BIT] : stb_mute) | (in_shut & slow_shut);

   // read data: data bytes in order, reset flag in the second byte
   wire [8*NUM_DATA-1:0] db_view = fault_report_pin_r | ((8*NUM_DATA)'(por_r) << (8 * DB_SECOND + POR_FLAG_BIT));
   assign bus.rd_data = (rd_cnt_r < 3'(NUM_DATA)) ? db_view[8*rd_cnt_r +: 8] : RD_FILL;
   assign bus.en      = bus_mode & stb_hi & addr_valid_r;
   assign bus.addr    = addr_r;

   amc_i2c_slave u_slave (
      .clk_in      (CLK_IN),
      .rstn_in     (RSTN_IN),
      .scl_in      (SCL_IN),
      .sda_in      (SDA_IN),
      .sda_oen_out (SDA_OEN_OUT),
      .bus         (bus)
   );

   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         addr_r       <= 7'h00;
         addr_valid_r <= 1'b0;
      end else if (SUPPLY_OK_IN) begin
         addr_r       <= asel_byte[7:1];
         addr_valid_r <= asel_ok;
      end else if (por_evt) begin
         addr_valid_r <= 1'b0;
      end
   end

   // amplifier state
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         amp_r <= ST_OFF;
      end else begin
         case (amp_r)
            ST_OFF: begin
               // legacy starts at mute or operate
               if (stb_hi) begin
                  amp_r <= bus_mode ? ST_IDLE : ST_RUN;
               end
            end
            ST_IDLE: begin
               if (!stb_hi || legacy) begin
                  amp_r <= ST_OFF;
               end else if (ib_r[IB_FIRST][START_BIT]) begin
                  amp_r <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (!stb_hi) begin
                  amp_r <= ST_SHUT;
               end
            end
            ST_SHUT: begin
               if (&muted_r) begin
                  amp_r <= ST_OFF;
               end
            end
            default: begin
               amp_r <= ST_OFF;
            end
         endcase
      end
   end

   // per pair mute timers
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_pair
         wire          target = soft_req[p] | hard_req;
         // unmute always takes the soft time
         wire [TW-1:0] limit  = (hard_req & target) ? TW'(HARD_CYC - 1) : TW'(SOFT_CYC - 1);
         always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
            if (!RSTN_IN) begin
               muted_r[p] <= 1'b1;
               tmr_r[p]   <= '0;
            end else if (!amp_live || target == muted_r[p]) begin
               muted_r[p] <= muted_r[p] | ~amp_live;
               tmr_r[p]   <= '0;
            end else if (tmr_r[p] >= limit) begin
               muted_r[p] <= target;
               tmr_r[p]   <= '0;
            end else begin
               tmr_r[p]   <= tmr_r[p] + TW'(1);
            end
         end
      end
   endgenerate

   // instruction bytes
   genvar b;
   generate
      for (b = 0; b < NUM_INSTR; b++) begin : g_ib
         always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
            if (!RSTN_IN) begin
               ib_r[b] <= INSTR_RST;
            end else if (por_evt || legacy) begin
               ib_r[b] <= INSTR_RST;
            end else if (ib_wr && wr_idx_r == 3'(b)) begin
               ib_r[b] <= bus.wr_data;
            end
         end
         assign INSTR_OUT[8*b +: 8] = ib_r[b];
      end
   endgenerate

   // transfer byte counters
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         wr_idx_r  <= 3'h0;
         rd_cnt_r  <= 3'h0;
         rd_xfer_r <= 1'b0;
      end else if (xfer_end) begin
         wr_idx_r  <= 3'h0;
         rd_cnt_r  <= 3'h0;
         rd_xfer_r <= 1'b0;
      end else begin
         if (bus.wr_valid && wr_idx_r != 3'h7) begin
            wr_idx_r <= wr_idx_r + 3'h1;
         end
         if (bus.rd_done) begin
            rd_xfer_r <= 1'b1;
            if (rd_cnt_r != 3'(NUM_DATA)) begin
               rd_cnt_r <= rd_cnt_r + 3'h1;
            end
         end
      end
   end

   // reset flag, diagnostic latches and fault pin
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         por_r       <= 1'b0;
         fault_report_pin_r      <= '0;
         fault_oen_r <= 1'b1;
      end else begin
         if (por_evt) begin
            por_r <= 1'b1;
         end else if (start_wr || legacy) begin
            por_r <= 1'b0;
         end
         fault_report_pin_r      <= (fault_report_pin_r & ~{(8*NUM_DATA){rd_clear}}) | FAULT_IN;
         fault_oen_r <= ~(por_r | (|(FAULT_IN & FAULT_PIN_MASK_IN)));
      end
   end

   assign SDA_OUT             = 1'b0;
   assign FAULT_PIN_OUT       = 1'b0;
   assign FAULT_PIN_OEN_OUT   = fault_oen_r;
   assign BUS_MODE_OUT        = bus_mode;
   assign ADDR_VALID_OUT      = addr_valid_r;
   assign SLAVE_ADDR_OUT      = addr_r;
   assign AMP_ON_OUT          = (amp_r != ST_OFF);
   assign AMP_STARTED_OUT     = amp_live;
   assign PAIR_MUTED_OUT      = muted_r;
   assign HARD_MUTE_OUT       = hard_req;
   assign CM_TRACK_SUPPLY_OUT = ib_r[IB_FOURTH][CM_TRACK_BIT];
   assign FAULT_REPORT_PIN_LATCH_OUT      = fault_report_pin_r;
   assign POR_FLAG_OUT        = por_r;
endmodule
`default_nettype wire

// ===== src/amc_i2c_slave.sv
// two-wire bus slave: address match, byte write and byte read
`default_nettype none
module amc_i2c_slave
   import amc_pkg::*;
(
   input  wire logic   clk_in,      // core clock
   input  wire logic   rstn_in,     // async reset, active low
   input  wire logic   scl_in,      // bus clock level
   input  wire logic   sda_in,      // bus data level
   output var  logic   sda_oen_out, // low while pulling data low
   amc_byte_if.slave   bus          // byte link to the core
);
   amc_sl_t    state_r;
   logic       scl_q_r;
   logic       sda_q_r;
   logic [7:0] sh_r;
   logic [7:0] tx_r;
   logic [3:0] cnt_r;
   logic       rw_r;
   logic       wr_valid_r;
   logic       rd_done_r;

   wire scl_rise  = scl_in & ~scl_q_r;
   wire scl_fall  = ~scl_in & scl_q_r;
   wire start_det = scl_in & scl_q_r & sda_q_r & ~sda_in;
   wire stop_det  = scl_in & scl_q_r & ~sda_q_r & sda_in;
   wire byte_full = (cnt_r == 4'h8);

   assign bus.start    = bus.en & start_det;
   assign bus.stop     = bus.en & stop_det;
   assign bus.rw       = rw_r;
   assign bus.wr_data  = sh_r;
   assign bus.wr_valid = wr_valid_r;
   assign bus.rd_done  = rd_done_r;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl_in;
         sda_q_r <= sda_in;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_r     <= SL_IDLE;
         sda_oen_out <= 1'b1;
         sh_r        <= 8'h00;
         tx_r        <= 8'h00;
         cnt_r       <= 4'h0;
         rw_r        <= 1'b0;
         wr_valid_r  <= 1'b0;
         rd_done_r   <= 1'b0;
      end else begin
         wr_valid_r <= 1'b0;
         rd_done_r  <= 1'b0;
         if (!bus.en || stop_det) begin
            state_r     <= SL_IDLE;
            sda_oen_out <= 1'b1;
         end else if (start_det) begin
            state_r     <= SL_ADDR;
            sda_oen_out <= 1'b1;
            cnt_r       <= 4'h0;
         end else begin
            case (state_r)
               SL_ADDR, SL_WRITE: begin
                  if (scl_rise) begin
                     sh_r  <= {sh_r[6:0], sda_in};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (scl_fall && byte_full) begin
                     if (state_r == SL_WRITE) begin
                        wr_valid_r  <= 1'b1;
                        sda_oen_out <= 1'b0;
                        state_r     <= SL_ACKW;
                     end else if (sh_r[7:1] == bus.addr) begin
                        rw_r        <= sh_r[0];
                        sda_oen_out <= 1'b0;
                        state_r     <= SL_ACKA;
                     end else begin
                        state_r <= SL_IDLE;
                     end
                  end
               end
               SL_ACKA, SL_ACKW, SL_RNEXT: begin
                  if (scl_fall) begin
                     cnt_r <= 4'h0;
                     if (state_r == SL_ACKW || !rw_r) begin
                        sda_oen_out <= 1'b1;
                        state_r     <= SL_WRITE;
                     end else begin
                        tx_r        <= bus.rd_data;
                        sda_oen_out <= bus.rd_data[7];
                        state_r     <= SL_READ;
                     end
                  end
               end
               SL_READ: begin
                  if (scl_fall) begin
                     if (cnt_r == 4'h7) begin
                        sda_oen_out <= 1'b1;
                        state_r     <= SL_RACK;
                     end else begin
                        tx_r        <= {tx_r[6:0], 1'b0};
                        sda_oen_out <= tx_r[6];
                        cnt_r       <= cnt_r + 4'h1;
                     end
                  end
               end
               SL_RACK: begin
                  if (scl_rise) begin
                     rd_done_r <= 1'b1;
                     state_r   <= sda_in ? SL_IDLE : SL_RNEXT;
                  end
               end
               default: begin
                  state_r     <= SL_IDLE;
                  sda_oen_out <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ===== src/amc_pkg.sv
// constants and types shared by the amplifier control logic
`default_nettype none
package amc_pkg;
   // timing figures as printed and their cycle counts at the core clock
   localparam int CLK_MHZ          = 125;
   localparam int SOFT_MUTE_MS     = 15;
   localparam int HARD_MUTE_US     = 400;
   localparam int SOFT_MUTE_CYC    = SOFT_MUTE_MS * 1000 * CLK_MHZ;
   localparam int HARD_MUTE_CYC    = HARD_MUTE_US * CLK_MHZ;

   // instruction and data byte layout
   localparam int NUM_INSTR        = 4;
   localparam int NUM_DATA         = 5;
   localparam int IB_FIRST         = 0;
   localparam int IB_SECOND        = 1;
   localparam int IB_FOURTH        = 3;
   localparam int DB_SECOND        = 1;
   localparam int START_BIT        = 0;
   localparam int FAST_MUTE_BIT    = 0;
   localparam int REAR_MUTE_BIT    = 1;
   localparam int FRONT_MUTE_BIT   = 2;
   localparam int SLOW_SHUT_BIT    = 6;
   localparam int CM_TRACK_BIT     = 7;
   localparam int POR_FLAG_BIT     = 7;
   localparam logic [7:0] INSTR_RST   = 8'h00;
   localparam logic [7:0] RD_FILL     = 8'h00;

   // slave address bytes with the direction bit at zero
   localparam logic [7:0] ADDR_R100K  = 8'hdc;
   localparam logic [7:0] ADDR_R30K   = 8'hde;
   localparam logic [7:0] ADDR_R10K   = 8'hd4;
   localparam logic [7:0] ADDR_HIGH   = 8'hda;

   // classified state of the address select pin
   typedef enum logic [2:0] {
      ASEL_SHORT = 3'h0,
      ASEL_R10K  = 3'h1,
      ASEL_R30K  = 3'h2,
      ASEL_R100K = 3'h3,
      ASEL_HIGH  = 3'h4,
      ASEL_OPEN  = 3'h5
   } amc_asel_t;

   // level of the standby pin; in bus mode any level but off is high
   typedef enum logic [1:0] {
      STB_OFF  = 2'h0,
      STB_MUTE = 2'h1,
      STB_OPER = 2'h2
   } amc_stb_t;

   typedef enum logic [3:0] {
      ST_OFF  = 4'h1,
      ST_IDLE = 4'h2,
      ST_RUN  = 4'h4,
      ST_SHUT = 4'h8
   } amc_amp_t;

   typedef enum logic [7:0] {
      SL_IDLE  = 8'h01,
      SL_ADDR  = 8'h02,
      SL_ACKA  = 8'h04,
      SL_WRITE = 8'h08,
      SL_ACKW  = 8'h10,
      SL_READ  = 8'h20,
      SL_RACK  = 8'h40,
      SL_RNEXT = 8'h80
   } amc_sl_t;
endpackage
`default_nettype wire
